/* File: csc_pkg.sv */
// Behaviour
// R01 - Ring enable bit gates ring indicate output.
// R02 - One ring enable shared by both functions.
// R03 - Video float bit tristates socket video pins.
// R04 - Port select picks video priority when both float.
// R05 - Card control bits four and three read zero.
// R06 - Audio route bit zero routes card audio.
// R07 - Both functions routing: function zero audio wins.
// R08 - Speaker out is XOR of both sockets.
// R09 - Speaker out driven only when either enabled.
// R10 - Functional interrupt flag kept per socket.
// R11 - Writing one clears interrupt flag; zero keeps.
// R12 - Protected bits cleared only by global reset.
// R13 - Global bits written only through function zero.
// R14 - Power hold refuses power down in D3.
// R15 - Low volt force bit resets to one.
// R16 - Diagnostic bit read/write, resets to one.
// R17 - Device control bit four reads zero.
// R18 - Software writes zero to vendor test bit.
// R19 - Software writes zero to device bit zero.
// R20 - Interrupt select chooses the signalling mode.
// R21 - Reserved interrupt code behaves as parallel only.
package csc_pkg;

	// One configuration byte.
	typedef logic [7:0] csc_byte_t;

	// Byte offsets in each function's configuration space.
	localparam csc_byte_t CSC_OFS_CARD_CTRL = 8'h91;
	localparam csc_byte_t CSC_OFS_DEV_CTRL  = 8'h92;

	// Reset values of the two registers.
	localparam csc_byte_t CSC_CARD_CTRL_RST = 8'h00;
	localparam csc_byte_t CSC_DEV_CTRL_RST  = 8'h66;

	// Card control field positions.
	localparam int CSC_CC_RING     = 7;
	localparam int CSC_CC_VFLOAT   = 6;
	localparam int CSC_CC_PORTSEL  = 5;
	localparam int CSC_CC_RSVD_HI  = 4;
	localparam int CSC_CC_RSVD_LO  = 3;
	localparam int CSC_CC_AUDIO    = 2;
	localparam int CSC_CC_CARD_SPEAKER_IN     = 1;
	localparam int CSC_CC_IRQFLAG  = 0;

	// Device control field positions.
	localparam int CSC_DC_PWRHOLD  = 7;
	localparam int CSC_DC_LOWVOLT  = 6;
	localparam int CSC_DC_DIAG     = 5;
	localparam int CSC_DC_RSVD     = 4;
	localparam int CSC_DC_TEST     = 3;
	localparam int CSC_DC_MODE_HI  = 2;
	localparam int CSC_DC_MODE_LO  = 1;
	localparam int CSC_DC_TEST0    = 0;

	// Interrupt signalling modes.
	typedef enum logic [1:0] {
		CSC_IRQ_PARALLEL = 2'h0,
		CSC_IRQ_RESERVED = 2'h1,
		CSC_IRQ_SER_AB   = 2'h2,
		CSC_IRQ_SERIAL   = 2'h3
	} csc_irq_mode_t;

	// Number of sockets, one per function.
	localparam int CSC_NUM_SOCKETS = 2;

endpackage

/* File: csc_slot_if.sv */
`timescale 1ns/10ps
// Carries one function's card control write and its stored fields.
interface csc_slot_if;
	logic      wr;          // Card control write strobe for this function.
	logic [7:0] wdata;      // Written byte.
	logic      irq_evt;     // Synchronised functional interrupt level.
	logic      video_float; // Socket video pins float.
	logic      port_sel;    // Video priority select.
	logic      audio_off;   // One leaves card audio unrouted.
	logic      card_speaker_in_en;     // Speaker merge enable.
	logic      irq_flag;    // Functional interrupt flag.

	// Register slice side.
	modport regs (
		input  wr, wdata, irq_evt,
		output video_float, port_sel, audio_off, card_speaker_in_en, irq_flag
	);
	// Top side.
	modport top (
		output wr, wdata, irq_evt,
		input  video_float, port_sel, audio_off, card_speaker_in_en, irq_flag
	);
endinterface // csc_slot_if

/* File: csc_slot_regs.sv */
`timescale 1ns/10ps
// Per-socket card control fields of one function.
module csc_slot_regs (
	input  wire logic i_core_clk, // Core clock.
	input  wire logic i_resetn,   // Global reset, active low.
	csc_slot_if.regs  slot        // Write port and fields.
);

	logic vf_q, vf_d;     // Video float.
	logic ps_q, ps_d;     // Port select.
	logic au_q, au_d;     // Audio unrouted.
	logic sp_q, sp_d;     // Speaker merge enable.
	logic irq_q, irq_d;   // Interrupt flag.

	// Next values; a new interrupt beats a clear in the same cycle.
	always_comb begin
		vf_d  = vf_q;
		ps_d  = ps_q;
		au_d  = au_q;
		sp_d  = sp_q;
		irq_d = irq_q;
		if (slot.wr) begin
			vf_d = slot.wdata[csc_pkg::CSC_CC_VFLOAT];
			ps_d = slot.wdata[csc_pkg::CSC_CC_PORTSEL];
			au_d = slot.wdata[csc_pkg::CSC_CC_AUDIO];
			sp_d = slot.wdata[csc_pkg::CSC_CC_CARD_SPEAKER_IN];
			if (slot.wdata[csc_pkg::CSC_CC_IRQFLAG]) begin
				irq_d = 1'b0; // R11
			end
		end
		if (slot.irq_evt) begin
			irq_d = 1'b1; // R10
		end
	end

	// Only the global reset clears these fields.
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			vf_q  <= csc_pkg::CSC_CARD_CTRL_RST[csc_pkg::CSC_CC_VFLOAT]; // R12
			ps_q  <= csc_pkg::CSC_CARD_CTRL_RST[csc_pkg::CSC_CC_PORTSEL];
			au_q  <= csc_pkg::CSC_CARD_CTRL_RST[csc_pkg::CSC_CC_AUDIO];
			sp_q  <= csc_pkg::CSC_CARD_CTRL_RST[csc_pkg::CSC_CC_CARD_SPEAKER_IN];
			irq_q <= csc_pkg::CSC_CARD_CTRL_RST[csc_pkg::CSC_CC_IRQFLAG];
		end else begin
			vf_q  <= vf_d;
			ps_q  <= ps_d;
			au_q  <= au_d;
			sp_q  <= sp_d;
			irq_q <= irq_d;
		end
	end

	assign slot.video_float = vf_q;
	assign slot.port_sel    = ps_q;
	assign slot.audio_off   = au_q;
	assign slot.card_speaker_in_en     = sp_q;
	assign slot.irq_flag    = irq_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	// An interrupt level always leaves the flag set.
	chk_irq_set_wins: assert property (slot.irq_evt |=> irq_q) // R10
		else $error("interrupt flag not set by event");
	// A one written with no event clears the flag.
	chk_irq_w1c: assert property ( // R11
		slot.wr && slot.wdata[0] && !slot.irq_evt |=> !irq_q)
		else $error("interrupt flag not cleared by write one");
	// A zero written with no event leaves the flag as it was.
	chk_irq_w0_keep: assert property ( // R11
		slot.wr && !slot.wdata[0] && !slot.irq_evt |=> irq_q == $past(irq_q))
		else $error("interrupt flag changed by write zero");
	cov_irq_clear: cover property (irq_q ##1 !irq_q);

endmodule // csc_slot_regs

/* File: csc_card_socket_regs.sv */
`timescale 1ns/10ps
// Card control and device control registers of a dual-socket bridge.
module csc_card_socket_regs (
	input  wire logic       i_core_clk,            // Core clock, 100 MHz.
	input  wire logic       i_resetn,              // Global reset, low.
	input  wire logic       i_bus_resetn,          // Host bus reset, low.
	input  wire logic       i_cfg_func,            // Function number.
	input  wire logic [7:0] i_cfg_addr,            // Config byte offset.
	input  wire logic       i_cfg_wr,              // Config byte write.
	input  wire logic       i_cfg_rd,              // Config byte read.
	input  wire logic [7:0] i_cfg_wdata,           // Write data.
	output logic      [7:0] o_cfg_rdata,           // Read data.
	output logic            o_cfg_rvalid,          // Read data valid.
	input  wire logic       i_ring_in,             // Ring from card pin.
	output logic            o_ring_indicate_out,   // Ring indicate out.
	output logic            o_ring_indicate_oe,    // Ring out enable.
	output logic      [1:0] o_video_float,         // Video pins float.
	output logic            o_video_select_socket0_n, // Socket 0 video.
	output logic            o_video_select_socket1_n, // Socket 1 video.
	input  wire logic [1:0] i_card_audio_in,       // Card audio pins.
	output logic            o_card_audio_pwm,      // Routed card audio.
	output logic            o_card_audio_pwm_oe,   // Audio routed.
	input  wire logic [1:0] i_card_speaker_in,     // Card speaker pins.
	output logic            o_speaker_out,         // Merged speaker.
	output logic            o_speaker_oe,          // Speaker driven.
	input  wire logic [1:0] i_card_func_irq,       // Card interrupts.
	input  wire logic [1:0] i_func_in_d3,          // Function in D3.
	input  wire logic [1:0] i_power_down_req,      // Power down request.
	output logic      [1:0] o_power_down_grant,    // Power down allowed.
	output logic            o_low_volt_capable,    // Socket 3-V capable.
	output logic      [1:0] o_irq_mode             // Effective irq mode.
);

	localparam int SYNC_W = 7; // Ring, two audio, two speaker, two irq.

	logic [SYNC_W-1:0] pins;      // Raw pin levels.
	logic [SYNC_W-1:0] sync1_q;   // First synchroniser stage.
	logic [SYNC_W-1:0] sync2_q;   // Second synchroniser stage.
	logic              ring_s;    // Synchronised ring.
	logic [1:0]        audio_s;   // Synchronised audio.
	logic [1:0]        card_speaker_in_s;    // Synchronised speaker.
	logic [1:0]        irq_s;     // Synchronised interrupt.

	logic       ring_q, ring_d;   // Shared ring enable.
	logic [1:0] hold_q, hold_d;   // Socket power hold, per function.
	logic [1:0] diag_q, diag_d;   // Diagnostic bit, per function.
	logic       lv_q, lv_d;       // Low volt force, global.
	logic       test_q, test_d;   // Vendor test bit, global.
	logic       test0_q, test0_d; // Test bit zero, global.
	logic [1:0] mode_q, mode_d;   // Interrupt select, global.

	logic [7:0] rdata_q, rdata_d; // Registered read data.
	logic       rvalid_q;         // Registered read valid.
	logic       wr_card;          // Card control write.
	logic       wr_dev;           // Device control write.

	csc_slot_if slot_if [csc_pkg::CSC_NUM_SOCKETS] (); // Socket slices.

	// Offset decode shared by write and read paths.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	assign pins = {i_card_func_irq, i_card_speaker_in, i_card_audio_in,
		i_ring_in};

	// Two flops per pin; only the second stage is read by logic.
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
		end
	end

	assign ring_s  = sync2_q[0];
	assign audio_s = sync2_q[2:1];
	assign card_speaker_in_s  = sync2_q[4:3];
	assign irq_s   = sync2_q[6:5];

	assign wr_card = i_cfg_wr && hit(i_cfg_addr, csc_pkg::CSC_OFS_CARD_CTRL);
	assign wr_dev  = i_cfg_wr && hit(i_cfg_addr, csc_pkg::CSC_OFS_DEV_CTRL);

	// One slice of per-socket fields for each function.
	for (genvar g = 0; g < csc_pkg::CSC_NUM_SOCKETS; g++) begin : g_slot
		// The cast keeps the compare one bit wide on both sides.
		assign slot_if[g].wr      = wr_card && (i_cfg_func == 1'(g));
		assign slot_if[g].wdata   = i_cfg_wdata;
		assign slot_if[g].irq_evt = irq_s[g];
		csc_slot_regs u_slot (
			.i_core_clk (i_core_clk),
			.i_resetn   (i_resetn),
			.slot       (slot_if[g])
		);
	end

	// Next values of the shared and device control bits.
	always_comb begin
		ring_d  = ring_q;
		hold_d  = hold_q;
		diag_d  = diag_q;
		lv_d    = lv_q;
		test_d  = test_q;
		test0_d = test0_q;
		mode_d  = mode_q;
		// Either function writes the one shared ring enable.
		if (wr_card) begin
			ring_d = i_cfg_wdata[csc_pkg::CSC_CC_RING]; // R02
		end
		if (wr_dev) begin
			// Power hold and diagnostic bits are per function.
			hold_d[i_cfg_func] = i_cfg_wdata[csc_pkg::CSC_DC_PWRHOLD];
			diag_d[i_cfg_func] = i_cfg_wdata[csc_pkg::CSC_DC_DIAG]; // R16
			// Global bits take writes from function zero only, so a
			// stray write through function one cannot alter them.
			if (!i_cfg_func) begin
				lv_d    = i_cfg_wdata[csc_pkg::CSC_DC_LOWVOLT]; // R13
				test_d  = i_cfg_wdata[csc_pkg::CSC_DC_TEST]; // R18
				test0_d = i_cfg_wdata[csc_pkg::CSC_DC_TEST0]; // R19
				mode_d  = i_cfg_wdata[csc_pkg::CSC_DC_MODE_HI:
					csc_pkg::CSC_DC_MODE_LO];
			end
		end
	end

	// Protected bits; the host bus reset deliberately does not reach them.
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			ring_q  <= csc_pkg::CSC_CARD_CTRL_RST[csc_pkg::CSC_CC_RING]; // R12
			hold_q  <= {2{csc_pkg::CSC_DEV_CTRL_RST[csc_pkg::CSC_DC_PWRHOLD]}};
			diag_q  <= {2{csc_pkg::CSC_DEV_CTRL_RST[csc_pkg::CSC_DC_DIAG]}};
			lv_q    <= csc_pkg::CSC_DEV_CTRL_RST[csc_pkg::CSC_DC_LOWVOLT]; // R15
			test_q  <= csc_pkg::CSC_DEV_CTRL_RST[csc_pkg::CSC_DC_TEST];
			test0_q <= csc_pkg::CSC_DEV_CTRL_RST[csc_pkg::CSC_DC_TEST0];
			mode_q  <= csc_pkg::CSC_DEV_CTRL_RST[csc_pkg::CSC_DC_MODE_HI:
				csc_pkg::CSC_DC_MODE_LO];
		end else begin
			ring_q  <= ring_d;
			hold_q  <= hold_d;
			diag_q  <= diag_d;
			lv_q    <= lv_d;
			test_q  <= test_d;
			test0_q <= test0_d;
			mode_q  <= mode_d;
		end
	end

	// Read mux; unmapped offsets read zero, reserved bits read zero.
	always_comb begin
		rdata_d = rdata_q;
		if (i_cfg_rd) begin
			rdata_d = 8'h00;
			if (hit(i_cfg_addr, csc_pkg::CSC_OFS_CARD_CTRL)) begin
				rdata_d[csc_pkg::CSC_CC_RING] = ring_q;
				if (!i_cfg_func) begin
					rdata_d[csc_pkg::CSC_CC_VFLOAT]  = slot_if[0].video_float;
					rdata_d[csc_pkg::CSC_CC_PORTSEL] = slot_if[0].port_sel;
					rdata_d[csc_pkg::CSC_CC_AUDIO]   = slot_if[0].audio_off;
					rdata_d[csc_pkg::CSC_CC_CARD_SPEAKER_IN]    = slot_if[0].card_speaker_in_en;
					rdata_d[csc_pkg::CSC_CC_IRQFLAG] = slot_if[0].irq_flag;
				end else begin
					rdata_d[csc_pkg::CSC_CC_VFLOAT]  = slot_if[1].video_float;
					rdata_d[csc_pkg::CSC_CC_PORTSEL] = slot_if[1].port_sel;
					rdata_d[csc_pkg::CSC_CC_AUDIO]   = slot_if[1].audio_off;
					rdata_d[csc_pkg::CSC_CC_CARD_SPEAKER_IN]    = slot_if[1].card_speaker_in_en;
					rdata_d[csc_pkg::CSC_CC_IRQFLAG] = slot_if[1].irq_flag;
				end
				// Bits four and three stay zero. R05
			end else if (hit(i_cfg_addr, csc_pkg::CSC_OFS_DEV_CTRL)) begin
				rdata_d[csc_pkg::CSC_DC_PWRHOLD] = hold_q[i_cfg_func];
				rdata_d[csc_pkg::CSC_DC_LOWVOLT] = lv_q;
				rdata_d[csc_pkg::CSC_DC_DIAG]    = diag_q[i_cfg_func];
				rdata_d[csc_pkg::CSC_DC_TEST]    = test_q;
				rdata_d[csc_pkg::CSC_DC_MODE_HI:csc_pkg::CSC_DC_MODE_LO] =
					mode_q;
				rdata_d[csc_pkg::CSC_DC_TEST0]   = test0_q;
				// Bit four stays zero. R17
			end
		end
	end

	// Read path belongs to the host bus and follows its reset too.
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn || !i_bus_resetn) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= i_cfg_rd;
		end
	end

	assign o_cfg_rdata  = rdata_q;
	assign o_cfg_rvalid = rvalid_q;

	// Ring passes only while enabled; the pin floats otherwise.
	assign o_ring_indicate_oe  = ring_q; // R01
	assign o_ring_indicate_out = ring_q && ring_s; // R01

	assign o_video_float = {slot_if[1].video_float, slot_if[0].video_float}; // R03

	// Video select; with both floating, function zero's port select decides.
	always_comb begin
		o_video_select_socket0_n = 1'b1;
		o_video_select_socket1_n = 1'b1;
		if (o_video_float == 2'h3) begin
			if (slot_if[0].port_sel) begin
				o_video_select_socket1_n = 1'b0; // R04
			end else begin
				o_video_select_socket0_n = 1'b0; // R04
			end
		end else if (o_video_float[0]) begin
			o_video_select_socket0_n = 1'b0;
		end else if (o_video_float[1]) begin
			o_video_select_socket1_n = 1'b0;
		end
	end

	// Audio: a clear bit routes; socket zero wins when both route.
	always_comb begin
		o_card_audio_pwm    = 1'b0;
		o_card_audio_pwm_oe = 1'b0;
		if (!slot_if[0].audio_off) begin
			o_card_audio_pwm    = audio_s[0]; // R07
			o_card_audio_pwm_oe = 1'b1; // R06
		end else if (!slot_if[1].audio_off) begin
			o_card_audio_pwm    = audio_s[1]; // R06
			o_card_audio_pwm_oe = 1'b1;
		end
	end

	// Speaker merge; data is held low when the pin is not driven.
	assign o_speaker_oe  = slot_if[0].card_speaker_in_en || slot_if[1].card_speaker_in_en; // R09
	assign o_speaker_out = o_speaker_oe && (card_speaker_in_s[0] ^ card_speaker_in_s[1]); // R08

	// A locked socket in D3 refuses power down requests.
	assign o_power_down_grant = i_power_down_req & ~(hold_q & i_func_in_d3); // R14

	assign o_low_volt_capable = lv_q;

	// The reserved code falls back to parallel, which never drops an irq.
	assign o_irq_mode = (mode_q == 2'h1) ? 2'h0 : mode_q; // R20 R21

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	chk_ring_shared: assert property ( // R02
		wr_card && i_cfg_func |=> ring_q == $past(i_cfg_wdata[7]))
		else $error("ring enable not written through function one");
	chk_ring_gated: assert property (!ring_q |-> !o_ring_indicate_out) // R01
		else $error("ring out active while disabled");
	chk_video_float: assert property ( // R03
		wr_card && !i_cfg_func |=> o_video_float[0] == $past(i_cfg_wdata[6]))
		else $error("video float not following write");
	chk_video_prio: assert property ( // R04
		o_video_float == 2'h3 && !slot_if[0].port_sel
		|-> !o_video_select_socket0_n && o_video_select_socket1_n)
		else $error("socket zero video priority wrong");
	chk_card_rsvd: assert property ( // R05
		i_cfg_rd && hit(i_cfg_addr, csc_pkg::CSC_OFS_CARD_CTRL)
		|=> o_cfg_rdata[4:3] == 2'h0)
		else $error("card control reserved bits not zero");
	chk_dev_rsvd: assert property ( // R17
		// A host bus reset on the read edge legally drops the valid strobe.
		i_cfg_rd && i_bus_resetn
		&& hit(i_cfg_addr, csc_pkg::CSC_OFS_DEV_CTRL)
		|=> !o_cfg_rdata[4] && o_cfg_rvalid)
		else $error("device control bit four not zero");
	chk_audio_f0: assert property ( // R07
		!slot_if[0].audio_off |-> o_card_audio_pwm == audio_s[0])
		else $error("function zero audio not routed");
	chk_speaker_xor: assert property ( // R08
		o_speaker_oe |-> o_speaker_out == (card_speaker_in_s[0] ^ card_speaker_in_s[1]))
		else $error("speaker merge wrong");
	chk_speaker_off: assert property ( // R09
		!slot_if[0].card_speaker_in_en && !slot_if[1].card_speaker_in_en |-> !o_speaker_oe)
		else $error("speaker driven while disabled");
	chk_power_hold: assert property ( // R14
		hold_q[0] && i_func_in_d3[0] |-> !o_power_down_grant[0])
		else $error("power down granted while held in D3");
	chk_global_f1: assert property ( // R13
		wr_dev && i_cfg_func |=> $stable(mode_q) && $stable(lv_q))
		else $error("global bit changed through function one");
	chk_mode_rsvd: assert property ( // R21
		wr_dev && !i_cfg_func && i_cfg_wdata[2:1] == 2'h1
		|=> o_irq_mode == 2'h0)
		else $error("reserved irq mode not parallel");
	chk_bus_reset_keep: assert property ( // R12
		!i_bus_resetn && !i_cfg_wr |=> $stable(ring_q) && $stable(mode_q))
		else $error("protected bit lost on bus reset");

	cov_ring_enabled:  cover property (wr_card ##1 ring_q);
	cov_both_float:    cover property (o_video_float == 2'h3);
	cov_speaker_merge: cover property (o_speaker_oe && o_speaker_out);
	cov_power_refused: cover property (|(i_power_down_req & ~o_power_down_grant));

endmodule // csc_card_socket_regs

/* File: csc_card_socket_regs_tb.sv */
`timescale 1ns/10ps
// Self-checking bench for the card and device control register pair.
module csc_card_socket_regs_tb;
	logic       core_clk;       // Core clock, 100 MHz.
	logic       resetn;         // Global reset, active low.
	logic       bus_resetn;     // Host bus reset, active low.
	logic       cfg_func;       // Function of the access.
	logic [7:0] cfg_addr;       // Byte offset.
	logic       cfg_wr;         // Write strobe.
	logic       cfg_rd;         // Read strobe.
	logic [7:0] cfg_wdata;      // Write data.
	logic [7:0] cfg_rdata;      // Read data.
	logic       cfg_rvalid;     // Read data valid.
	logic       ring_in;        // Ring pin.
	logic       ring_out;       // Ring indicate out.
	logic       ring_oe;        // Ring indicate enable.
	logic [1:0] video_float;    // Video float per socket.
	logic       vsel0_n;        // Socket 0 video select, low.
	logic       vsel1_n;        // Socket 1 video select, low.
	logic [1:0] audio_in;       // Card audio pins.
	logic       audio_pwm;      // Routed card audio.
	logic       audio_oe;       // Card audio routed.
	logic [1:0] card_speaker_in_in;        // Card speaker pins.
	logic       card_speaker_in_out;       // Merged speaker.
	logic       card_speaker_in_oe;        // Speaker driven.
	logic [1:0] func_irq;       // Card functional interrupts.
	logic [1:0] in_d3;          // Function in D3.
	logic [1:0] pd_req;         // Power down requests.
	logic [1:0] pd_grant;       // Power down grants.
	logic       low_volt;       // Socket 3-V capable.
	logic [1:0] irq_mode;       // Effective interrupt mode.
	int         miscompares;    // Mismatches seen.
	int         compares;       // Comparisons made.

	// All inputs start at rest so nothing floats at time zero.
	initial begin
		core_clk = 1'b0;
		{cfg_func, cfg_wr, cfg_rd, ring_in} = 4'h0;
		cfg_addr = 8'h00;
		cfg_wdata = 8'h00;
		{audio_in, card_speaker_in_in, func_irq, in_d3, pd_req} = 10'h000;
		bus_resetn = 1'b1;
		miscompares = 0;
		compares = 0;
	end

	// Free-running core clock, 10 ns period.
	always #5 core_clk = ~core_clk;

	csc_card_socket_regs uut (
		.i_core_clk(core_clk), .i_resetn(resetn), .i_bus_resetn(bus_resetn),
		.i_cfg_func(cfg_func), .i_cfg_addr(cfg_addr), .i_cfg_wr(cfg_wr),
		.i_cfg_rd(cfg_rd), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
		.o_cfg_rvalid(cfg_rvalid), .i_ring_in(ring_in),
		.o_ring_indicate_out(ring_out), .o_ring_indicate_oe(ring_oe),
		.o_video_float(video_float), .o_video_select_socket0_n(vsel0_n),
		.o_video_select_socket1_n(vsel1_n), .i_card_audio_in(audio_in),
		.o_card_audio_pwm(audio_pwm), .o_card_audio_pwm_oe(audio_oe),
		.i_card_speaker_in(card_speaker_in_in), .o_speaker_out(card_speaker_in_out),
		.o_speaker_oe(card_speaker_in_oe), .i_card_func_irq(func_irq),
		.i_func_in_d3(in_d3), .i_power_down_req(pd_req),
		.o_power_down_grant(pd_grant), .o_low_volt_capable(low_volt),
		.o_irq_mode(irq_mode));

	// Byte compare; unknowns never match thanks to case equality.
	task automatic chk8(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Single-bit compare.
	task automatic chk1(input string n, input logic e, g);
		chk8(n, {7'h00, e}, {7'h00, g});
	endtask

	// Prints the verdict and ends the run.
	task automatic report_and_stop;
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Lets the pin synchronisers settle after an input change.
	task automatic settle;
		repeat (4) @(negedge core_clk);
	endtask

	// One-cycle write strobe, launched off the falling edge.
	task automatic wr(input logic f, input logic [7:0] a, d);
		@(negedge core_clk);
		cfg_func = f;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge core_clk);
		cfg_wr = 1'b0;
	endtask

	// Read with data judged in the one cycle that valid stands.
	task automatic rd(input logic f, input logic [7:0] a, e);
		@(negedge core_clk);
		cfg_func = f;
		cfg_addr = a;
		cfg_rd = 1'b1;
		@(negedge core_clk);
		cfg_rd = 1'b0;
		chk1("rvalid", 1'b1, cfg_rvalid);
		chk8("rdata", e, cfg_rdata);
	endtask

	// Global reset mid-run, three edges to flush synchronisers too.
	task automatic global_reset;
		@(negedge core_clk);
		resetn = 1'b0;
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
	endtask

	// Reset values of both registers, both functions, and of the pins.
	task automatic t_reset;
		rd(1'b0, 8'h91, 8'h00);
		rd(1'b1, 8'h91, 8'h00);
		rd(1'b0, 8'h92, 8'h66);
		rd(1'b1, 8'h92, 8'h66);
		rd(1'b0, 8'h93, 8'h00);
		chk1("ring_oe", 1'b0, ring_oe);
		chk1("card_speaker_in_oe", 1'b0, card_speaker_in_oe);
		chk8("irq_mode", 8'h03, {6'h00, irq_mode});
		chk1("low_volt", 1'b1, low_volt);
	endtask

	// Ring enable written through function 1 is seen through function 0.
	task automatic t_ring;
		wr(1'b1, 8'h91, 8'h80);
		chk1("ring_oe", 1'b1, ring_oe);
		rd(1'b0, 8'h91, 8'h80);
		ring_in = 1'b1;
		settle();
		chk1("ring_out", 1'b1, ring_out);
		wr(1'b0, 8'h91, 8'h00);
		chk1("ring_oe off", 1'b0, ring_oe);
		chk1("ring_out off", 1'b0, ring_out);
		ring_in = 1'b0;
	endtask

	// Reserved bits stay zero and a written one does not set the flag.
	task automatic t_card_rsvd;
		wr(1'b0, 8'h91, 8'hff);
		rd(1'b0, 8'h91, 8'he6);
		wr(1'b0, 8'h91, 8'h00);
	endtask

	// Video float per socket and priority when both float.
	task automatic t_video;
		wr(1'b0, 8'h91, 8'h40);
		chk8("vfloat", 8'h01, {6'h00, video_float});
		chk8("vsel one", 8'h02, {6'h00, vsel1_n, vsel0_n});
		wr(1'b1, 8'h91, 8'h40);
		chk8("vfloat both", 8'h03, {6'h00, video_float});
		chk8("vsel pri0", 8'h02, {6'h00, vsel1_n, vsel0_n});
		wr(1'b0, 8'h91, 8'h60);
		chk8("vsel pri1", 8'h01, {6'h00, vsel1_n, vsel0_n});
		wr(1'b0, 8'h91, 8'h00);
		wr(1'b1, 8'h91, 8'h00);
	endtask

	// Card audio routing polarity and function 0 winning.
	task automatic t_audio;
		audio_in = 2'h1;
		settle();
		chk1("audio_oe", 1'b1, audio_oe);
		chk1("audio fn0", 1'b1, audio_pwm);
		wr(1'b0, 8'h91, 8'h04);
		chk1("audio fn1 lo", 1'b0, audio_pwm);
		audio_in = 2'h2;
		settle();
		chk1("audio fn1 hi", 1'b1, audio_pwm);
		wr(1'b1, 8'h91, 8'h04);
		chk1("audio off", 1'b0, audio_oe);
		wr(1'b0, 8'h91, 8'h00);
		wr(1'b1, 8'h91, 8'h00);
	endtask

	// Speaker merge is the XOR of both sockets, driven only when enabled.
	task automatic t_speaker;
		card_speaker_in_in = 2'h3;
		settle();
		chk1("card_speaker_in_oe off", 1'b0, card_speaker_in_oe);
		wr(1'b1, 8'h91, 8'h02);
		chk1("card_speaker_in_oe on", 1'b1, card_speaker_in_oe);
		chk1("card_speaker_in xor 11", 1'b0, card_speaker_in_out);
		card_speaker_in_in = 2'h1;
		settle();
		chk1("card_speaker_in xor 01", 1'b1, card_speaker_in_out);
		wr(1'b1, 8'h91, 8'h00);
		chk1("card_speaker_in_oe again", 1'b0, card_speaker_in_oe);
	endtask

	// Interrupt flag per socket, cleared only by writing one.
	task automatic t_irq_flag;
		func_irq = 2'h2;
		settle();
		func_irq = 2'h0;
		settle();
		rd(1'b1, 8'h91, 8'h01);
		rd(1'b0, 8'h91, 8'h00);
		wr(1'b1, 8'h91, 8'h00);
		rd(1'b1, 8'h91, 8'h01);
		wr(1'b1, 8'h91, 8'h01);
		rd(1'b1, 8'h91, 8'h00);
		// Socket 0: a clear while the interrupt still stands loses.
		func_irq = 2'h1;
		settle();
		wr(1'b0, 8'h91, 8'h01);
		rd(1'b0, 8'h91, 8'h01);
		func_irq = 2'h0;
		settle();
		wr(1'b0, 8'h91, 8'h01);
		rd(1'b0, 8'h91, 8'h00);
	endtask

	// Global and per-function device bits, modes and power hold.
	task automatic t_dev_ctrl;
		logic [1:0] code;
		wr(1'b0, 8'h92, 8'hf6);
		rd(1'b0, 8'h92, 8'he6);
		wr(1'b1, 8'h92, 8'h00);
		rd(1'b1, 8'h92, 8'h46);
		rd(1'b0, 8'h92, 8'he6);
		in_d3 = 2'h3;
		pd_req = 2'h3;
		@(negedge core_clk);
		chk8("grant d3", 8'h02, {6'h00, pd_grant});
		in_d3 = 2'h0;
		@(negedge core_clk);
		chk8("grant d0", 8'h03, {6'h00, pd_grant});
		for (int i = 0; i < 4; i++) begin
			code = i[1:0];
			wr(1'b0, 8'h92, {4'ha, 1'b0, code, 1'b0});
			chk8("irq_mode", (code == 2'h1) ? 8'h00 : {6'h00, code},
				{6'h00, irq_mode});
			rd(1'b0, 8'h92, {4'ha, 1'b0, code, 1'b0});
		end
		chk1("low_volt", 1'b0, low_volt);
		pd_req = 2'h0;
	endtask

	// Host bus reset keeps the control bits; global reset returns them to their reset values.
	task automatic t_resets;
		wr(1'b0, 8'h91, 8'h40);
		@(negedge core_clk);
		bus_resetn = 1'b0;
		repeat (3) @(negedge core_clk);
		bus_resetn = 1'b1;
		rd(1'b0, 8'h91, 8'h40);
		rd(1'b0, 8'h92, 8'ha6);
		global_reset();
		rd(1'b0, 8'h91, 8'h00);
		rd(1'b0, 8'h92, 8'h66);
	endtask

	// Main sequence: reset held for 16 cycles, then every scenario.
	initial begin
		resetn = 1'b0;
		repeat (16) @(negedge core_clk);
		resetn = 1'b1;
		t_reset();
		t_ring();
		t_card_rsvd();
		t_video();
		t_audio();
		t_speaker();
		t_irq_flag();
		t_dev_ctrl();
		t_resets();
		report_and_stop();
	end

	// Watchdog well beyond the roughly 160 cycles the scenarios need.
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		report_and_stop();
	end
endmodule // csc_card_socket_regs_tb
